// ===== atx_map.vh
`ifndef ATX_MAP_VH
`define ATX_MAP_VH
`define ATX_FIFO_DEPTH      32
`define ATX_HALF_LEVEL      6'h10
`define ATX_HS_PHASE        9'h005
`define ATX_HS_GAP          9'h028
`define ATX_LS_PHASE        9'h028
`define ATX_LS_GAP          9'h140
`define ATX_CLK_MHZ         250
`define ATX_DATA_CLK_MHZ    1
`define ATX_TICK_DIV        (`ATX_CLK_MHZ / `ATX_DATA_CLK_MHZ)
`define ATX_START_LAT_X10   25
`define ATX_BITS_PARITY     6'h1F
`define ATX_BITS_FULL       6'h20
`endif

// ===== atx_top.v
`timescale 1ns/1ns
`include "atx_map.vh"
module atx_top #(
    parameter DEPTH = `ATX_FIFO_DEPTH,
    parameter AW    = 5,
    parameter TICK  = `ATX_TICK_DIV
)(
    input  wire        clk,
    input  wire        rstn,
    input  wire        master_reset_pin,
    input  wire        transmit_enable_pin,
    input  wire        low_speed,
    input  wire        parity_insert_bit,
    input  wire        parity_sense_bit,
    input  wire        loopback_select_bit,
    input  wire        repeater_mode,
    input  wire        low_half_load_strobe,
    input  wire        high_half_load_strobe,
    input  wire [15:0] host_data,
    input  wire        rx_word_read,
    input  wire [31:0] rx_word,
    output reg         serial_out_pair_a,
    output reg         serial_out_pair_b,
    output reg         rx1_loop_a,
    output reg         rx1_loop_b,
    output reg         rx2_loop_a,
    output reg         rx2_loop_b,
    output reg         loop_active,
    output reg         tx_empty_flag,
    output reg         tx_half_full_flag,
    output reg         tx_full_flag
);

// ------------------------------------------------------------
// Queue
// ------------------------------------------------------------
reg  [31:0]  mem [0:DEPTH-1];
reg  [AW-1:0] wr_ptr_reg;
reg  [AW-1:0] rd_ptr_reg;
reg  [AW:0]   count_reg;
reg  [15:0]   low_half_reg;
reg           enable_d_reg;
wire          clear = !rstn || master_reset_pin;
wire          pop;

// Repeater words arrive whole; no half order is assumed.
// repeater copy
// A repeater read and a host upper half in one cycle: the read wins and
// the host word is lost, so hosts should not mix both sources at once.
wire          rep_load = repeater_mode && rx_word_read;
wire          host_load = high_half_load_strobe && !rep_load;
wire          load = rep_load || host_load;
wire [31:0]   load_word = rep_load ? rx_word : {host_data, low_half_reg};
wire          push = load && (count_reg != DEPTH);

// ------------------------------------------------------------
// Helpers
// ------------------------------------------------------------
// Phase and gap counters share one end test.
function cnt_last;
    input [8:0] cnt;
    input [8:0] len;
    begin
        cnt_last = (cnt == len - 9'h001);
    end
endfunction

function par_bit;
    input ones_odd;
    input sense;
    begin
        par_bit = ~ones_odd ^ sense;
    end
endfunction

function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
        ptr_inc = (p == DEPTH - 1) ? {AW{1'b0}} : p + 1'b1;
    end
endfunction

always @(posedge clk)
begin
    if (low_half_load_strobe)
    begin
        low_half_reg <= host_data;
    end
    if (push)
    begin
        mem[wr_ptr_reg] <= load_word;
    end
end

always @(posedge clk)
begin
    if (clear)
    begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
        begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
        end
        if (pop)
        begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
        end
        count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
end

// ------------------------------------------------------------
// Serializer
// ------------------------------------------------------------
localparam S_IDLE = 2'd0;
localparam S_DATA = 2'd1;
localparam S_NULL = 2'd2;
localparam S_GAP  = 2'd3;

reg  [1:0]  state_reg;
reg  [31:0] shift_reg;
reg  [5:0]  bit_cnt_reg;
reg  [8:0]  phase_cnt_reg;
reg  [8:0]  tick_cnt_reg;
reg         cur_bit_reg;
reg         parity_reg;
reg         par_ins_reg;
wire        tick = (tick_cnt_reg == TICK - 1);
reg  [8:0]  phase_len;
reg  [8:0]  gap_len;
reg  [5:0]  nbits;
always @*
begin
    if (low_speed)
    begin
        phase_len = `ATX_LS_PHASE;
        gap_len   = `ATX_LS_GAP;
    end
    else
    begin
        phase_len = `ATX_HS_PHASE;
        gap_len   = `ATX_HS_GAP;
    end
    // word length
    // With parity on, the last of the 32 slots carries the parity bit.
    nbits = `ATX_BITS_FULL;
end
wire        enable_rise = transmit_enable_pin && !enable_d_reg;
assign pop = (state_reg == S_IDLE) && (count_reg != 0) &&
             (enable_rise || transmit_enable_pin);

// Starting in the cycle after the pop, with the tick counter cleared, keeps the first bit within one data clock.
always @(posedge clk)
begin
    if (clear)
    begin
        state_reg     <= S_IDLE;
        shift_reg     <= 32'h00000000;
        bit_cnt_reg   <= 6'h00;
        phase_cnt_reg <= 9'h000;
        tick_cnt_reg  <= 9'h000;
        cur_bit_reg   <= 1'b0;
        parity_reg    <= 1'b0;
        par_ins_reg   <= 1'b0;
        enable_d_reg  <= 1'b0;
    end
    else
    begin
        enable_d_reg <= transmit_enable_pin;
        tick_cnt_reg <= tick ? 9'h000 : tick_cnt_reg + 9'h001;
        case (state_reg)
            S_IDLE:
            begin
                if (pop)
                begin
                    shift_reg     <= mem[rd_ptr_reg];
                    par_ins_reg   <= parity_insert_bit;
                    parity_reg    <= 1'b0;
                    bit_cnt_reg   <= 6'h00;
                    phase_cnt_reg <= 9'h000;
                    tick_cnt_reg  <= 9'h000;
                    cur_bit_reg   <= mem[rd_ptr_reg][0];
                    state_reg     <= S_DATA;
                end
            end
            S_DATA:
            begin
                if (tick)
                begin
                    if (cnt_last(phase_cnt_reg, phase_len))
                    begin
                        phase_cnt_reg <= 9'h000;
                        state_reg     <= S_NULL;
                    end
                    else
                    begin
                        phase_cnt_reg <= phase_cnt_reg + 9'h001;
                    end
                end
            end
            S_NULL:
            begin
                if (tick)
                begin
                    if (cnt_last(phase_cnt_reg, phase_len))
                    begin
                        phase_cnt_reg <= 9'h000;
                        parity_reg    <= parity_reg ^ cur_bit_reg;
                        bit_cnt_reg   <= bit_cnt_reg + 6'h01;
                        shift_reg     <= {1'b0, shift_reg[31:1]};
                        if (bit_cnt_reg == nbits - 6'h01)
                        begin
                            state_reg <= S_GAP;
                        end
                        else
                        begin
                            state_reg <= S_DATA;
                            if (par_ins_reg &&
                                bit_cnt_reg == `ATX_BITS_PARITY - 1)
                            begin
                                cur_bit_reg <= par_bit(parity_reg ^ cur_bit_reg,
                                                       parity_sense_bit);
                            end
                            else
                            begin
                                cur_bit_reg <= shift_reg[1];
                            end
                        end
                    end
                    else
                    begin
                        phase_cnt_reg <= phase_cnt_reg + 9'h001;
                    end
                end
            end
            S_GAP:
            begin
                if (tick)
                begin
                    if (cnt_last(phase_cnt_reg, gap_len))
                    begin
                        phase_cnt_reg <= 9'h000;
                        state_reg     <= S_IDLE;
                    end
                    else
                    begin
                        phase_cnt_reg <= phase_cnt_reg + 9'h001;
                    end
                end
            end
            default:
            begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

// ------------------------------------------------------------
// Outputs
// ------------------------------------------------------------
// null when idle
wire drv_a = (state_reg == S_DATA) && cur_bit_reg;
wire drv_b = (state_reg == S_DATA) && !cur_bit_reg;

always @(posedge clk)
begin
    if (clear)
    begin
        serial_out_pair_a <= 1'b0;
        serial_out_pair_b <= 1'b0;
        rx1_loop_a        <= 1'b0;
        rx1_loop_b        <= 1'b0;
        rx2_loop_a        <= 1'b0;
        rx2_loop_b        <= 1'b0;
        loop_active       <= 1'b0;
        tx_empty_flag     <= 1'b1;
        tx_half_full_flag <= 1'b1;
        tx_full_flag      <= 1'b0;
    end
    else
    begin
        // control kept
        // Control bits are plain ports, so a master reset cannot alter them;
        // only the derived loop flag drops for the single reset cycle; the rx1/rx2 loop copies stay low until the serializer sends again.
        // output always driven
        serial_out_pair_a <= drv_a;
        serial_out_pair_b <= drv_b;
        loop_active <= !loopback_select_bit;
        rx1_loop_a <= !loopback_select_bit && drv_a;
        rx1_loop_b <= !loopback_select_bit && drv_b;
        rx2_loop_a <= !loopback_select_bit && drv_b;
        rx2_loop_b <= !loopback_select_bit && drv_a;
        tx_empty_flag <= (count_reg == 0) && (state_reg == S_IDLE) && !pop
                         && !push;
        tx_half_full_flag <= (count_reg < `ATX_HALF_LEVEL);
        tx_full_flag <= (count_reg == DEPTH);
    end
end

endmodule

// ===== atx_monitor.sv
`timescale 1ns/1ns
module atx_monitor #(
    parameter TICK = 250
)(
    input logic clk,
    input logic rstn,
    input logic master_reset_pin,
    input logic transmit_enable_pin,
    input logic low_speed,
    input logic loopback_select_bit,
    input logic serial_out_pair_a,
    input logic serial_out_pair_b,
    input logic rx1_loop_a,
    input logic rx1_loop_b,
    input logic rx2_loop_a,
    input logic rx2_loop_b,
    input logic loop_active,
    input logic tx_empty_flag,
    input logic tx_half_full_flag,
    input logic tx_full_flag
);
    // ----------------------------------------
    // Line checks
    // ----------------------------------------
    localparam int LAT = (25 * TICK) / 10;
    logic       busy;
    logic [15:0] run_reg;
    assign busy = serial_out_pair_a || serial_out_pair_b;
    // Counts a data phase; a reset cuts the phase short.
    always_ff @(posedge clk)
    begin
        if (!rstn || master_reset_pin || !busy)
            run_reg <= 16'h0000;
        else
            run_reg <= run_reg + 16'h0001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_phase;
        disable iff (!rstn || master_reset_pin)
        busy ##1 !busy |-> run_reg == (low_speed ? 40 * TICK : 5 * TICK);
    endproperty
    a_phase: assert property (p_phase)
        else $error("data phase length wrong");
    property p_start;
        disable iff (!rstn || master_reset_pin)
        $rose(transmit_enable_pin) && !tx_empty_flag |-> ##[1:LAT] busy;
    endproperty
    a_start: assert property (p_start)
        else $error("first bit late");
    property p_mreset;
        master_reset_pin |=> !busy && tx_empty_flag && tx_half_full_flag
            && !tx_full_flag;
    endproperty
    a_mreset: assert property (p_mreset)
        else $error("master reset left state");
    property p_loopact;
        !master_reset_pin |=> loop_active == !$past(loopback_select_bit);
    endproperty
    a_loopact: assert property (p_loopact)
        else $error("loop flag wrong");
    property p_swap;
        rx2_loop_a == rx1_loop_b && rx2_loop_b == rx1_loop_a;
    endproperty
    a_swap: assert property (p_swap)
        else $error("second receiver not inverted");
    property p_loopoff;
        loopback_select_bit && $past(loopback_select_bit)
            && $past(loopback_select_bit, 2) |-> !rx1_loop_a && !rx1_loop_b;
    endproperty
    a_loopoff: assert property (p_loopoff)
        else $error("loop copy while off");
    property p_flags;
        tx_full_flag |-> !tx_half_full_flag && !tx_empty_flag;
    endproperty
    a_flags: assert property (p_flags)
        else $error("flags disagree");
    property p_pair;
        !(serial_out_pair_a && serial_out_pair_b);
    endproperty
    a_pair: assert property (p_pair)
        else $error("both lines high");
    c_full: cover property (tx_full_flag);
    c_loop: cover property (loop_active && rx1_loop_a);
    c_low: cover property (low_speed && serial_out_pair_a);
endmodule

// ===== atx_host_model.sv
`timescale 1ns/1ns
module atx_host_model (
    input  logic        clk,
    output logic        low_half_load_strobe,
    output logic        high_half_load_strobe,
    output logic [15:0] host_data,
    output logic        rx_word_read,
    output logic [31:0] rx_word
);
    initial
    begin
        low_half_load_strobe = 1'b0;
        high_half_load_strobe = 1'b0;
        host_data = 16'h0000;
        rx_word_read = 1'b0;
        rx_word = 32'h0000_0000;
    end
    // lower half first.
    // The bus is inverted after each strobe since its hold has run out.
    task automatic load(input logic [31:0] w);
        @(posedge clk) #1;
        host_data = w[15:0];
        low_half_load_strobe = 1'b1;
        @(posedge clk) #1;
        low_half_load_strobe = 1'b0;
        host_data = ~w[15:0];
        @(posedge clk) #1;
        host_data = w[31:16];
        high_half_load_strobe = 1'b1;
        @(posedge clk) #1;
        high_half_load_strobe = 1'b0;
        host_data = ~w[31:16];
    endtask
    task automatic read_rx(input logic [31:0] w);
        @(posedge clk) #1;
        rx_word = w;
        rx_word_read = 1'b1;
        @(posedge clk) #1;
        rx_word_read = 1'b0;
        rx_word = ~w;
    endtask
endmodule

// ===== atx_top_bench.sv
`timescale 1ns/1ns
module atx_top_bench;
    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    typedef struct packed {logic ls, pi, ps; logic [31:0] w, e;} atx_row_t;
    logic clk = 1'b0, rstn = 1'b0, master_reset_pin = 1'b0;
    logic transmit_enable_pin = 1'b0, low_speed = 1'b0;
    logic parity_insert_bit = 1'b0, parity_sense_bit = 1'b0;
    logic loopback_select_bit = 1'b1, repeater_mode = 1'b0;
    logic low_half_load_strobe, high_half_load_strobe, rx_word_read;
    logic [15:0] host_data;
    logic [31:0] rx_word, got;
    logic serial_out_pair_a, serial_out_pair_b, rx1_loop_a, rx1_loop_b;
    logic rx2_loop_a, rx2_loop_b, loop_active;
    logic tx_empty_flag, tx_half_full_flag, tx_full_flag;
    int n_mismatch = 0, checked = 0;
    always #2 clk = ~clk;
    atx_top #(.TICK(2)) atx_top_inst (.*);
    atx_host_model atx_host_model_inst (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Samples each bit two cycles into its data phase, after lags settle.
    task automatic get_word(output logic [31:0] w);
        int t;
        for (int i = 0; i < 32; i++)
        begin
            t = 0;
            while (!(serial_out_pair_a || serial_out_pair_b) && t < 2000)
            begin
                cyc(1);
                t++;
            end
            chk(32'(t < 2000), 32'h1);
            cyc(2);
            w[i] = serial_out_pair_a;
            if (!loopback_select_bit)
                chk(32'(rx1_loop_a), 32'(serial_out_pair_a));
            while (serial_out_pair_a || serial_out_pair_b)
                cyc(1);
        end
    endtask
    task automatic wait_empty;
        for (int t = 0; t < 2000 && !tx_empty_flag; t++)
            cyc(1);
        chk(32'(tx_empty_flag), 32'h1);
        transmit_enable_pin = 1'b0;
    endtask
    task automatic end_of_test;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_mismatch++;
        end_of_test;
    end
    initial
    begin
        atx_row_t rows [6] = '{
            '{1'b0, 1'b1, 1'b0, 32'h0000_0001, 32'h0000_0001},
            '{1'b0, 1'b1, 1'b1, 32'h0000_0001, 32'h8000_0001},
            '{1'b0, 1'b1, 1'b0, 32'hFFFF_FFFF, 32'h7FFF_FFFF},
            '{1'b0, 1'b1, 1'b1, 32'h8000_0000, 32'h0000_0000},
            '{1'b0, 1'b0, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
            '{1'b1, 1'b0, 1'b0, 32'h1234_5678, 32'h1234_5678}};
        cyc(5);
        rstn = 1'b1;
        cyc(1);
        chk(32'({tx_empty_flag, tx_half_full_flag, tx_full_flag}), 32'h6);
        $display("reset test done");
        foreach (rows[i])
        begin
            low_speed = rows[i].ls;
            parity_insert_bit = rows[i].pi;
            parity_sense_bit = rows[i].ps;
            loopback_select_bit = (i > 2);
            atx_host_model_inst.load(rows[i].w);
            cyc(3);
            transmit_enable_pin = 1'b1;
            get_word(got);
            chk(got, rows[i].e);
            wait_empty();
            $display("row %0d done", i);
        end
        parity_insert_bit = 1'b0;
        low_speed = 1'b0;
        for (int i = 0; i < 33; i++)
        begin
            atx_host_model_inst.load(32'hA500_0000 + 32'(i));
            cyc(3);
            if (i == 14 || i == 15)
                chk(32'(tx_half_full_flag), 32'(i == 14));
            if (i == 30 || i == 31)
                chk(32'(tx_full_flag), 32'(i == 31));
        end
        transmit_enable_pin = 1'b1;
        for (int j = 0; j < 32; j++)
        begin
            get_word(got);
            chk(got, 32'hA500_0000 + 32'(j));
        end
        wait_empty();
        cyc(200);
        chk(32'({serial_out_pair_a, serial_out_pair_b}), 32'h0);
        $display("fill test done");
        repeater_mode = 1'b1;
        atx_host_model_inst.read_rx(32'h5A5A_0F0F);
        cyc(3);
        repeater_mode = 1'b0;
        transmit_enable_pin = 1'b1;
        get_word(got);
        chk(got, 32'h5A5A_0F0F);
        wait_empty();
        $display("repeater test done");
        loopback_select_bit = 1'b0;
        atx_host_model_inst.load(32'hFFFF_FFFF);
        atx_host_model_inst.load(32'hFFFF_FFFF);
        cyc(3);
        transmit_enable_pin = 1'b1;
        cyc(30);
        master_reset_pin = 1'b1;
        cyc(1);
        master_reset_pin = 1'b0;
        chk(32'({serial_out_pair_a, serial_out_pair_b, tx_empty_flag,
            tx_half_full_flag, tx_full_flag}), 32'h6);
        cyc(1);
        chk(32'(loop_active), 32'h1);
        cyc(100);
        chk(32'({serial_out_pair_a, serial_out_pair_b}), 32'h0);
        transmit_enable_pin = 1'b0;
        $display("master reset test done");
        end_of_test;
    end
endmodule
bind atx_top atx_monitor #(.TICK(TICK)) atx_monitor_inst (.*);
